// >>> verilog/hvft_regs.sv
// Added by the designer: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "hvft_defines.svh"

// How it works
// - short threshold selectors, pins 8..5, rw
// - open-load threshold selectors, pins 8..5, rw
// - high-side force-off bit n-1 for pin n
// - force-off one keeps high side off
// - force-off zero follows pin control; preset zero
// - override registers non-volatile, writes need unlock
// - status: ok, open, short, off codes
module hvft_regs
    import hvft_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rstn,
    // ahb-lite slave
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // per-pin driver requests from the pin control registers
    input  wire logic [7:0]  i_hs_request,
    input  wire logic [7:0]  i_ls_request,
    // analog comparator flags, asynchronous
    input  wire logic [7:0]  i_short_detect,
    input  wire logic [7:0]  i_open_detect,
    // non-volatile image of the override registers
    input  wire logic [7:0]  i_nv_hs_image,
    input  wire logic [7:0]  i_nv_ls_image,
    output logic             o_nv_write,
    output logic             o_nv_write_ls,
    output logic      [7:0]  o_nv_write_data,
    // driver enables and threshold selects toward the pins
    output logic      [7:0]  o_hs_enable,
    output logic      [7:0]  o_ls_enable,
    output logic      [7:0]  o_short_detect_current_level,
    output logic      [7:0]  o_open_detect_current_level
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        hvft_phase_e phase;      // data phase in progress
        hvft_idx_t   idx;        // latched register index
        logic        hit;        // latched address was in range
        logic [31:0] hrdata;     // read data
        logic        hready;     // registered ready
        logic        nv_loaded;  // image taken after reset
        logic        unlock;     // restricted write access open
        hvft_byte_t  short_sel;  // short thresholds
        hvft_byte_t  open_sel;   // open-load thresholds
        hvft_byte_t  hs_force;   // high-side force-off
        hvft_byte_t  ls_force;   // low-side force-off
        hvft_byte_t  sc_level;   // threshold select to analog
        hvft_byte_t  ol_level;   // threshold select to analog
        hvft_byte_t  hs_en;      // high-side enables
        hvft_byte_t  ls_en;      // low-side enables
        logic        nv_wr;      // nv programming pulse
        logic        nv_wr_ls;   // which register is programmed
        hvft_byte_t  nv_data;    // value to program
    } hvft_regs_s;

    hvft_regs_s r_q;
    hvft_regs_s r_d;

    hvft_stat_t [7:0] pin_status;  // from per-pin evaluators

    // upper address bits must be zero for a register hit
    function automatic logic in_range(input logic [31:0] addr);
        in_range = (addr[31:12] == 20'h00000);
    endfunction

    // readback mux, unmapped indices read as zero
    function automatic logic [31:0] read_mux(input hvft_idx_t idx,
                                             input hvft_regs_s r,
                                             input hvft_stat_t [7:0] s);
        read_mux = 32'h00000000;
        case (idx)
            `HVFT_IDX_STATUS_LO:
                read_mux = {24'h000000, s[3], s[2], s[1], s[0]};
            `HVFT_IDX_STATUS_HI:
                read_mux = {24'h000000, s[7], s[6], s[5], s[4]};
            `HVFT_IDX_SHORT_SEL:
                read_mux = {24'h000000, r.short_sel};
            `HVFT_IDX_OPEN_SEL:
                read_mux = {24'h000000, r.open_sel};
            `HVFT_IDX_HS_FORCE_OFF:
                read_mux = {24'h000000, r.hs_force};
            `HVFT_IDX_LS_FORCE_OFF:
                read_mux = {24'h000000, r.ls_force};
            `HVFT_IDX_NV_UNLOCK:
                read_mux = {31'h00000000, r.unlock};
            default:
                read_mux = 32'h00000000;                // unmapped
        endcase
    endfunction

    // ********************************************************
    // next state
    // ********************************************************
    always_comb begin
        r_d        = r_q;
        r_d.nv_wr  = 1'b0;
        r_d.hready = 1'b1;

        // first cycle after reset: adopt the stored override image,
        // so settings survive a power cycle
        if (!r_q.nv_loaded) begin
            r_d.nv_loaded = 1'b1;
            r_d.hs_force  = i_nv_hs_image;
            r_d.ls_force  = i_nv_ls_image;
        end

        // data phase work
        case (r_q.phase)
            HVFT_WRITE: begin
                r_d.phase = HVFT_IDLE;
                if (r_q.hit) begin
                    case (r_q.idx)
                        `HVFT_IDX_SHORT_SEL:
                            r_d.short_sel = i_hwdata[7:0];
                        `HVFT_IDX_OPEN_SEL:
                            r_d.open_sel = i_hwdata[7:0];
                        `HVFT_IDX_HS_FORCE_OFF: begin
                            // locked writes are dropped silently
                            if (r_q.unlock) begin
                                r_d.hs_force = i_hwdata[7:0];
                                r_d.nv_wr    = 1'b1;
                                r_d.nv_wr_ls = 1'b0;
                                r_d.nv_data  = i_hwdata[7:0];
                            end
                        end
                        `HVFT_IDX_LS_FORCE_OFF: begin
                            if (r_q.unlock) begin
                                r_d.ls_force = i_hwdata[7:0];
                                r_d.nv_wr    = 1'b1;
                                r_d.nv_wr_ls = 1'b1;
                                r_d.nv_data  = i_hwdata[7:0];
                            end
                        end
                        `HVFT_IDX_NV_UNLOCK:
                            r_d.unlock =
                                (i_hwdata[7:0] == `HVFT_NV_UNLOCK_KEY);
                        default: begin
                            // unmapped: ignored, still okay
                        end
                    endcase
                end
            end
            HVFT_READ: begin
                // one wait state so a read after a write sees it
                r_d.phase  = HVFT_IDLE;
                r_d.hrdata = r_q.hit ? read_mux(r_q.idx, r_q, pin_status)
                                     : 32'h00000000;
            end
            default: begin
                r_d.phase = HVFT_IDLE;
            end
        endcase

        // address phase accepted only while the bus is ready
        if (i_hsel && i_htrans[1] && i_hready) begin
            r_d.idx = i_haddr[11:2];
            r_d.hit = in_range(i_haddr);
            if (i_hwrite) begin
                r_d.phase = HVFT_WRITE;
            end else begin
                r_d.phase  = HVFT_READ;
                r_d.hready = 1'b0;
            end
        end

        // thresholds reach the comparators one cycle after commit
        r_d.sc_level = r_q.short_sel;
        r_d.ol_level = r_q.open_sel;

        // force-off overrides the pin's own request; the value being
        // committed is used, so no enable slips out on the cycle the
        // stored image is adopted after reset
        r_d.hs_en = i_hs_request & ~r_d.hs_force;
        r_d.ls_en = i_ls_request & ~r_d.ls_force;
    end

    // ********************************************************
    // registers, synchronous reset
    // ********************************************************
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            r_q           <= '0;
            r_q.phase     <= HVFT_IDLE;
            r_q.hready    <= 1'b1;
            r_q.short_sel <= `HVFT_RST_SHORT_SEL;
            r_q.open_sel  <= `HVFT_RST_OPEN_SEL;
            r_q.hs_force  <= `HVFT_RST_FORCE_OFF;
            r_q.ls_force  <= `HVFT_RST_FORCE_OFF;
        end else begin
            r_q <= r_d;
        end
    end

    // ********************************************************
    // per-pin status evaluation
    // ********************************************************
    genvar p;
    generate
        for (p = 0; p < `HVFT_NPINS; p = p + 1) begin : g_pin
            hvft_pin_status u_stat (
                .i_clock     (i_clock),
                .i_rstn      (i_rstn),
                .i_short_raw (i_short_detect[p]),
                .i_open_raw  (i_open_detect[p]),
                .i_driver_on (r_q.hs_en[p] | r_q.ls_en[p]),
                .o_status    (pin_status[p])
            );
        end
    endgenerate

    // ********************************************************
    // outputs, all straight from flops except o_hresp, tied low
    // ********************************************************
    assign o_hrdata                     = r_q.hrdata;
    assign o_hreadyout                  = r_q.hready;
    assign o_hresp                      = 1'b0;
    assign o_nv_write                   = r_q.nv_wr;
    assign o_nv_write_ls                = r_q.nv_wr_ls;
    assign o_nv_write_data              = r_q.nv_data;
    assign o_hs_enable                  = r_q.hs_en;
    assign o_ls_enable                  = r_q.ls_en;
    assign o_short_detect_current_level = r_q.sc_level;
    assign o_open_detect_current_level  = r_q.ol_level;

endmodule

// >>> verilog/hvft_defines.svh
`ifndef HVFT_DEFINES_SVH
`define HVFT_DEFINES_SVH

// ********************************************************
// register indices (byte address is four times the index)
// ********************************************************
`define HVFT_IDX_STATUS_LO     10'h036
`define HVFT_IDX_STATUS_HI     10'h046
`define HVFT_IDX_SHORT_SEL     10'h049
`define HVFT_IDX_OPEN_SEL      10'h04A
`define HVFT_IDX_HS_FORCE_OFF  10'h071
`define HVFT_IDX_LS_FORCE_OFF  10'h072
`define HVFT_IDX_NV_UNLOCK     10'h07E

// ********************************************************
// field layout and reset values
// ********************************************************
`define HVFT_SEL_W             2
`define HVFT_NPINS             8
`define HVFT_NV_UNLOCK_KEY     8'hA5
`define HVFT_RST_SHORT_SEL     8'h00
`define HVFT_RST_OPEN_SEL      8'h00
`define HVFT_RST_FORCE_OFF     8'h00

// ********************************************************
// driver status codes
// ********************************************************
`define HVFT_ST_OK             2'h0
`define HVFT_ST_OPEN           2'h1
`define HVFT_ST_SHORT          2'h2
`define HVFT_ST_OFF            2'h3

`endif

// >>> verilog/hvft_pkg.sv
package hvft_pkg;

    // ********************************************************
    // shared types
    // ********************************************************
    typedef logic [7:0]  hvft_byte_t;   // one register value
    typedef logic [1:0]  hvft_stat_t;   // per-pin driver status
    typedef logic [9:0]  hvft_idx_t;    // register word index

    // bus slave phase tracking, one-hot
    typedef enum logic [2:0] {
        HVFT_IDLE  = 3'h1,
        HVFT_WRITE = 3'h2,
        HVFT_READ  = 3'h4
    } hvft_phase_e;

endpackage

// >>> verilog/hvft_pin_status.sv
`timescale 1ns/1ps
`include "hvft_defines.svh"

// one pin: synchronise comparator flags and encode driver status
module hvft_pin_status
    import hvft_pkg::*;
(
    input  wire logic       i_clock,
    input  wire logic       i_rstn,
    input  wire logic       i_short_raw,
    input  wire logic       i_open_raw,
    input  wire logic       i_driver_on,
    output hvft_stat_t      o_status
);

    // ********************************************************
    // state
    // ********************************************************
    typedef struct packed {
        logic       sc_meta;    // first sync stage, short flag
        logic       sc;         // second sync stage, short flag
        logic       ol_meta;    // first sync stage, open flag
        logic       ol;         // second sync stage, open flag
        hvft_stat_t status;     // encoded status
    } hvft_pin_s;

    hvft_pin_s st_q;
    hvft_pin_s st_d;

    // short outranks open: a shorted load also draws no open current
    always_comb begin
        st_d         = st_q;
        st_d.sc_meta = i_short_raw;
        st_d.sc      = st_q.sc_meta;
        st_d.ol_meta = i_open_raw;
        st_d.ol      = st_q.ol_meta;
        if (!i_driver_on) begin
            st_d.status = `HVFT_ST_OFF;
        end else if (st_q.sc) begin
            st_d.status = `HVFT_ST_SHORT;
        end else if (st_q.ol) begin
            st_d.status = `HVFT_ST_OPEN;
        end else begin
            st_d.status = `HVFT_ST_OK;
        end
    end

    // synchronous reset, driver reported off until first evaluation
    always_ff @(posedge i_clock) begin
        if (!i_rstn) begin
            st_q        <= '0;
            st_q.status <= `HVFT_ST_OFF;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_status = st_q.status;

endmodule

// >>> verif/hvft_regs_chk.sv
`timescale 1ns/1ps
// ****
// bus timing and override checks
// ****
module hvft_regs_chk (
    input wire logic        i_clock,
    input wire logic        i_rstn,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [31:0] i_hwdata,
    input wire logic        i_hready,
    input wire logic        o_hreadyout,
    input wire logic        o_hresp,
    input wire logic [7:0]  i_hs_request,
    input wire logic        o_nv_write,
    input wire logic        o_nv_write_ls,
    input wire logic [7:0]  o_nv_write_data,
    input wire logic [7:0]  o_hs_enable,
    input wire logic [7:0]  o_short_detect_current_level,
    input wire logic [7:0]  o_open_detect_current_level
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    // a transfer is taken on this edge
    logic go;
    assign go = i_hsel & i_htrans[1] & i_hready;
    // write of one register, taken now
    sequence s_wr(a);
        go && i_hwrite && i_haddr == a;
    endsequence
    // read costs one wait state, write none
    property p_rd; go && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout;
    endproperty
    property p_wr; go && i_hwrite |=> o_hreadyout; endproperty
    property p_resp; o_hresp == 1'b0; endproperty
    // a high-side enable never appears without its request
    property p_hs_mask; (o_hs_enable & ~$past(i_hs_request)) == 8'h00;
    endproperty
    // forced pins drop together with the store pulse; checked one cycle later
    property p_force; o_nv_write && !o_nv_write_ls
        |=> (o_hs_enable & $past(o_nv_write_data)) == 8'h00; endproperty
    property p_nv_data; o_nv_write |-> o_nv_write_data == $past(i_hwdata[7:0]);
    endproperty
    property p_sh_lvl; s_wr(32'h124) |->
        ##3 o_short_detect_current_level == $past(i_hwdata[7:0], 2); endproperty
    property p_op_lvl; s_wr(32'h128) |->
        ##3 o_open_detect_current_level == $past(i_hwdata[7:0], 2); endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
    a_wr: assert property (p_wr) else $error("write stalled");
    a_resp: assert property (p_resp) else $error("response not okay");
    a_hs_mask: assert property (p_hs_mask) else $error("hs on, no request");
    a_force: assert property (p_force) else $error("forced pin on");
    a_nv_data: assert property (p_nv_data) else $error("store data");
    a_sh_lvl: assert property (p_sh_lvl) else $error("short sel");
    a_op_lvl: assert property (p_op_lvl) else $error("open sel");
endmodule

// >>> verif/hvft_far_model.sv
`timescale 1ns/1ps
// ****
// far side: pin loads and override storage
// ****
module hvft_far_model (
    input  wire logic       i_clock,
    input  wire logic [7:0] i_hs_enable,
    input  wire logic [7:0] i_ls_enable,
    input  wire logic [7:0] i_short_mask,
    input  wire logic [7:0] i_open_mask,
    input  wire logic       i_nv_write,
    input  wire logic       i_nv_write_ls,
    input  wire logic [7:0] i_nv_write_data,
    output logic      [7:0] o_short_flag,
    output logic      [7:0] o_open_flag,
    output logic      [7:0] o_nv_hs_image = 8'h00, // preset zero
    output logic      [7:0] o_nv_ls_image = 8'h00
);
    // a faulty load only trips its comparator while the pin is driven
    assign o_short_flag = i_short_mask & (i_hs_enable | i_ls_enable);
    assign o_open_flag  = i_open_mask & (i_hs_enable | i_ls_enable);
    // cells ignore reset, so values survive a power cycle
    always @(posedge i_clock) begin
        if (i_nv_write && !i_nv_write_ls)
            o_nv_hs_image <= i_nv_write_data;
        if (i_nv_write && i_nv_write_ls)
            o_nv_ls_image <= i_nv_write_data;
    end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
// ****
// register bank bench
// ****
module testbench;
    localparam logic [31:0] A_SH = 32'h124, A_OP = 32'h128, A_ST = 32'h118;
    localparam logic [31:0] A_HS = 32'h1C4, A_LS = 32'h1C8, A_KEY = 32'h1F8;
    logic        clk    = 1'b0;
    logic        rstn   = 1'b0;
    logic        hsel   = 1'b0;
    logic        hwrite = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr  = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0]  hs_req = 8'h00;
    logic [7:0]  ls_req = 8'h00;
    logic [7:0]  sh_msk = 8'h00;
    logic [7:0]  op_msk = 8'h00;
    logic [31:0] hrdata;
    logic        hready, nv_wr, nv_ls;
    logic [7:0]  nv_dat, hs_en, ls_en, sh_lvl, op_lvl, sh_f, op_f, hs_i, ls_i;
    logic [7:0]  v;
    int          n_errors = 0;
    int          check_count = 0;
    hvft_regs u_dut (.i_clock(clk), .i_rstn(rstn), .i_hsel(hsel),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
        .o_hreadyout(hready), .o_hresp(), .i_hs_request(hs_req),
        .i_ls_request(ls_req), .i_short_detect(sh_f), .i_open_detect(op_f),
        .i_nv_hs_image(hs_i), .i_nv_ls_image(ls_i), .o_nv_write(nv_wr),
        .o_nv_write_ls(nv_ls), .o_nv_write_data(nv_dat), .o_hs_enable(hs_en),
        .o_ls_enable(ls_en), .o_short_detect_current_level(sh_lvl),
        .o_open_detect_current_level(op_lvl));
    hvft_far_model u_far (.i_clock(clk), .i_hs_enable(hs_en),
        .i_ls_enable(ls_en), .i_short_mask(sh_msk), .i_open_mask(op_msk),
        .i_nv_write(nv_wr), .i_nv_write_ls(nv_ls), .i_nv_write_data(nv_dat),
        .o_short_flag(sh_f), .o_open_flag(op_f), .o_nv_hs_image(hs_i),
        .o_nv_ls_image(ls_i));
    initial forever #2.5 clk = ~clk;
    // ****
    // tasks
    // ****
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // bounded wait for hready sampled high at a rising edge
    task automatic wait_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (hready !== 1'b1 && n < 64);
        if (hready !== 1'b1) begin
            n_errors++;
            tally_and_finish;
        end
    endtask
    // one single word transfer; entered just after a rising edge
    task automatic xfer(input logic w, input logic [31:0] a, d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy;
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, {24'h0, d}, r);
    endtask
    task automatic rchk(input logic [31:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(r, {24'h0, e});
    endtask
    task automatic rst;
        rstn <= 1'b0;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
    endtask
    // ****
    // tests
    // ****
    initial begin
        rst;
        rchk(A_HS, 8'h00);
        rchk(A_ST, 8'hFF);
        rchk(32'h0D8, 8'hFF);
        // every code lands once in every field
        for (int c = 0; c < 4; c++) begin
            v = 8'(8'h55 * c) ^ 8'h1B;
            wr(A_SH, v);
            wr(A_OP, ~v);
            rchk(A_SH, v);
            rchk(A_OP, ~v);
            chk({24'h0, sh_lvl}, {24'h0, v});
            chk({24'h0, op_lvl}, {24'h0, ~v});
        end
        // upper address bits set: no hit, last value stays
        wr(32'h00001124, 8'h00);
        rchk(A_SH, 8'hE4);
        $display("thresholds done");
        // locked store and unmapped place both drop writes
        wr(A_HS, 8'h81);
        rchk(A_HS, 8'h00);
        wr(32'h300, 8'h5A);
        rchk(32'h300, 8'h00);
        wr(A_KEY, 8'hA5);
        rchk(A_KEY, 8'h01);
        wr(A_HS, 8'h81);
        wr(A_LS, 8'h0F);
        rchk(A_HS, 8'h81);
        hs_req <= 8'hFF;
        ls_req <= 8'hFF;
        repeat (3) @(posedge clk);
        chk({24'h0, hs_en}, 32'h7E);
        chk({24'h0, ls_en}, 32'hF0);
        $display("override done");
        // pin6 short and open, pin7 open: short wins
        sh_msk <= 8'h20;
        op_msk <= 8'h60;
        repeat (8) @(posedge clk);
        rchk(A_ST, 8'h18);
        rchk(32'h0D8, 8'h03);
        $display("status done");
        // relocked: this store must be dropped, 81 survives the reset
        wr(A_KEY, 8'h00);
        wr(A_HS, 8'h00);
        rst;
        rchk(A_HS, 8'h81);
        rchk(A_LS, 8'h0F);
        chk({24'h0, hs_en}, 32'h7E);
        $display("persistence done");
        tally_and_finish;
    end
endmodule
bind hvft_regs hvft_regs_chk u_chk (.i_clock, .i_rstn, .i_hsel, .i_haddr,
    .i_htrans, .i_hwrite, .i_hwdata, .i_hready, .o_hreadyout, .o_hresp,
    .i_hs_request, .o_nv_write, .o_nv_write_ls, .o_nv_write_data,
    .o_hs_enable, .o_short_detect_current_level, .o_open_detect_current_level);
